//--- ubm_pkg.sv
/*
 * Shared constants and types for the endpoint bank manager: register map,
 * flag bit positions, reset values, link-side carriers and control phases.
 * Assumes a 32-bit classic Wishbone register bus and a byte-wide link side.
 */
package ubm_pkg;

	// ****************************************************************
	// Sizes and register map
	// ****************************************************************
	localparam int BANK_BYTES_DEF = 64;
	localparam int NUM_BANKS_DEF = 2;
	localparam logic [31:0] ADDR_CFG = 32'h00000000;
	localparam logic [31:0] ADDR_FLAGS = 32'h00000004;
	localparam logic [31:0] ADDR_COUNT = 32'h00000008;
	localparam logic [31:0] ADDR_DATA = 32'h0000000c;

	// ****************************************************************
	// Flag register bit positions
	// ****************************************************************
	localparam int FLG_TXIN = 0;
	localparam int FLG_OUT = 2;
	localparam int FLG_SETUP = 3;
	localparam int FLG_NAK = 6;
	localparam int FLG_BCTL = 7;
	localparam int FLG_RW_ALLOWED_FLAG = 8;
	localparam int FLG_ZLS = 9;
	localparam int FLG_FREE = 10;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {UBM_EP_CTRL, UBM_EP_OUT, UBM_EP_IN} ubm_ep_t;
	typedef struct packed {
		logic setup_ie;
		logic in_ie;
		logic out_ie;
		logic two_bank;
		logic dfc;
		logic auto_sw;
		ubm_ep_t ep;
	} ubm_cfg_t;
	typedef struct packed {
		logic zls;
		logic bctl;
		logic nak;
		logic setup;
		logic out;
		logic txin;
	} ubm_flags_t;
	typedef enum logic [1:0] {UBM_TOK_SETUP, UBM_TOK_OUT, UBM_TOK_IN} ubm_tok_kind_t;
	typedef struct packed {logic valid; ubm_tok_kind_t kind;} ubm_tok_t;
	typedef struct packed {logic valid; logic eop; logic [7:0] data;} ubm_rx_t;
	typedef struct packed {logic valid; logic last; logic [7:0] data;} ubm_tx_t;
	typedef struct packed {logic valid; logic nak;} ubm_hs_t;
	typedef enum logic [2:0] {UBM_CT_IDLE, UBM_CT_WR, UBM_CT_RD, UBM_CT_RD_ST, UBM_CT_WAIT} ubm_ctl_t;

	localparam ubm_cfg_t CFG_RST = '0;
	localparam ubm_flags_t FLAGS_RST = '0;

endpackage : ubm_pkg

//--- ubm_bank_mgr.sv
/*
 * Endpoint bank manager: one endpoint (control, OUT or IN) with one or two
 * data banks, served by the CPU over Wishbone or by a data flow controller.
 * Assumes the link side delivers well-formed tokens and packets, one at a
 * time, and issues no token while an IN packet is being streamed.
 */
`timescale 1ns/1ps
module ubm_bank_mgr #(
	parameter int BANK_BYTES = ubm_pkg::BANK_BYTES_DEF,
	parameter int NUM_BANKS = ubm_pkg::NUM_BANKS_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// USB link side
	input wire ubm_pkg::ubm_tok_t lnk_tok_i,
	input wire ubm_pkg::ubm_rx_t lnk_rx_i,
	output ubm_pkg::ubm_hs_t lnk_hs_o,
	output ubm_pkg::ubm_tx_t lnk_tx_o,
	// Data flow controller
	input wire logic dfc_rd_i,
	input wire logic dfc_wr_i,
	input wire logic [7:0] dfc_wdata_i,
	output logic [7:0] dfc_rdata_o,
	// Endpoint interrupt
	output logic ep_irq_o
);

	localparam int PW = $clog2(BANK_BYTES + 1);
	localparam int AW = $clog2(NUM_BANKS * BANK_BYTES);

	// ****************************************************************
	// State
	// ****************************************************************
	ubm_pkg::ubm_cfg_t cfg_q, cfg_d;
	ubm_pkg::ubm_flags_t flg_q, flg_d;
	ubm_pkg::ubm_ctl_t ctl_q, ctl_d;
	ubm_pkg::ubm_hs_t hs_q, hs_d;
	ubm_pkg::ubm_tx_t tx_q, tx_d;
	logic [NUM_BANKS-1:0] full_q, full_d;
	logic [PW-1:0] cnt_q [NUM_BANKS];
	logic [PW-1:0] cnt_d [NUM_BANKS];
	logic [PW-1:0] ptr_q, ptr_d, hptr_q, hptr_d;
	logic cbank_q, cbank_d, hbank_q, hbank_d;
	logic rx_ok_q, rx_ok_d, rx_setup_q, rx_setup_d, rx_retry_q, rx_retry_d;
	logic tx_busy_q, tx_busy_d, seen_q, seen_d;
	logic ack_q, ack_d, irq_q, irq_d;
	logic [31:0] dat_q, dat_d;
	logic [7:0] dfc_q, dfc_d;
	logic [7:0] mem_q [NUM_BANKS * BANK_BYTES];
	logic mem_we;
	logic [AW-1:0] mem_wa;
	logic [7:0] mem_wd;

	// ****************************************************************
	// Decoded conditions
	// ****************************************************************
	logic req, ctrl, is_out, is_in, two, hb, nb_c, nb_h, cur_full, rw_allowed_flag;
	logic cpu_rd, cpu_wr, rd_ev, wr_ev, last_rd, fill, rel_ev;
	logic [PW-1:0] cur_cnt;
	logic [10:0] wclr;
	logic [7:0] cur_byte, wdat;

	function automatic logic [AW-1:0] ma(input logic b, input logic [PW-1:0] p);
		ma = AW'(int'(b) * BANK_BYTES + int'(p));
	endfunction : ma

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign ctrl = cfg_q.ep == ubm_pkg::UBM_EP_CTRL;
	assign is_out = cfg_q.ep == ubm_pkg::UBM_EP_OUT;
	assign is_in = cfg_q.ep == ubm_pkg::UBM_EP_IN;
	// The control endpoint always works on a single bank.
	assign two = cfg_q.two_bank && (NUM_BANKS > 1) && !ctrl;
	assign hb = ctrl ? 1'b0 : hbank_q;
	assign nb_c = two ? ~cbank_q : cbank_q;
	assign nb_h = two ? ~hb : hb;
	assign cur_full = full_q[cbank_q];
	assign cur_cnt = cnt_q[cbank_q];
	assign cur_byte = mem_q[ma(cbank_q, ptr_q)];
	assign rw_allowed_flag = is_out ? (cur_full && ptr_q < cur_cnt) :
		is_in ? (!cur_full && ptr_q < PW'(BANK_BYTES)) : 1'b0;
	assign wclr = (req && wb_we_i && wb_adr_i == ubm_pkg::ADDR_FLAGS) ?
		{wb_sel_i[1] ? wb_dat_i[10:8] : 3'h0, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00} : 11'h000;
	assign cpu_rd = req && !wb_we_i && wb_adr_i == ubm_pkg::ADDR_DATA && wb_sel_i[0] &&
		!cfg_q.dfc && (ctrl ? ptr_q < cnt_q[0] : rw_allowed_flag && is_out);
	assign cpu_wr = req && wb_we_i && wb_adr_i == ubm_pkg::ADDR_DATA && wb_sel_i[0] &&
		!cfg_q.dfc && (ctrl ? !full_q[0] && ptr_q < PW'(BANK_BYTES) : rw_allowed_flag && is_in);
	assign rd_ev = cpu_rd || (dfc_rd_i && cfg_q.dfc && is_out && rw_allowed_flag);
	assign wr_ev = cpu_wr || (dfc_wr_i && cfg_q.dfc && is_in && rw_allowed_flag);
	assign wdat = cpu_wr ? wb_dat_i[7:0] : dfc_wdata_i;
	assign last_rd = rd_ev && is_out && (ptr_q + 1'b1) == cur_cnt;
	assign fill = wr_ev && is_in && (ptr_q + 1'b1) == PW'(BANK_BYTES);
	assign rel_ev = !ctrl && ((wclr[ubm_pkg::FLG_BCTL] && flg_q.bctl && !cfg_q.auto_sw) ||
		wclr[ubm_pkg::FLG_FREE] || (cfg_q.auto_sw && (last_rd || fill)));

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		cfg_d = cfg_q;
		flg_d = flg_q;
		ctl_d = ctl_q;
		full_d = full_q;
		cnt_d = cnt_q;
		ptr_d = ptr_q;
		hptr_d = hptr_q;
		cbank_d = cbank_q;
		hbank_d = hbank_q;
		rx_ok_d = rx_ok_q;
		rx_setup_d = rx_setup_q;
		rx_retry_d = rx_retry_q;
		tx_busy_d = tx_busy_q;
		seen_d = seen_q;
		hs_d = '0;
		tx_d = '0;
		dfc_d = dfc_q;
		ack_d = req;
		dat_d = 32'h00000000;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = 8'h00;
		if (req && wb_we_i && wb_adr_i == ubm_pkg::ADDR_CFG && wb_sel_i[0]) begin
			cfg_d = ubm_pkg::ubm_cfg_t'(wb_dat_i[7:0]);
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				ubm_pkg::ADDR_CFG: dat_d = {24'h000000, cfg_q};
				ubm_pkg::ADDR_FLAGS: dat_d = {22'h000000, flg_q.zls, rw_allowed_flag,
					flg_q.bctl && !ctrl, flg_q.nak, 2'b00, flg_q.setup, flg_q.out,
					1'b0, flg_q.txin};
				ubm_pkg::ADDR_COUNT: dat_d = 32'(cur_cnt);
				ubm_pkg::ADDR_DATA: dat_d = cpu_rd ? {24'h000000, cur_byte} : 32'h00000000;
				default: dat_d = 32'h00000000;
			endcase
		end
		// Clears come first so that a hardware set in the same cycle wins.
		flg_d.out = flg_q.out && !wclr[ubm_pkg::FLG_OUT];
		flg_d.txin = flg_q.txin && !wclr[ubm_pkg::FLG_TXIN];
		flg_d.setup = flg_q.setup && !wclr[ubm_pkg::FLG_SETUP];
		flg_d.nak = flg_q.nak && !wclr[ubm_pkg::FLG_NAK];
		flg_d.zls = flg_q.zls && !wclr[ubm_pkg::FLG_ZLS];
		if (ctrl && ((wclr[ubm_pkg::FLG_OUT] && flg_q.out) ||
				(wclr[ubm_pkg::FLG_SETUP] && flg_q.setup))) begin
			full_d[0] = 1'b0;
			cnt_d[0] = '0;
			ptr_d = '0;
			flg_d.txin = 1'b1;
		end
		if (ctrl && wclr[ubm_pkg::FLG_TXIN] && flg_q.txin &&
				!(ctl_q inside {ubm_pkg::UBM_CT_RD_ST, ubm_pkg::UBM_CT_WAIT})) begin
			full_d[0] = 1'b1;
			ptr_d = '0;
		end
		if (rd_ev) begin
			ptr_d = ptr_q + 1'b1;
			dfc_d = cfg_q.dfc ? cur_byte : dfc_q;
		end
		if (wr_ev) begin
			mem_we = 1'b1;
			mem_wa = ma(cbank_q, ptr_q);
			mem_wd = wdat;
			ptr_d = ptr_q + 1'b1;
			cnt_d[cbank_q] = ptr_q + 1'b1;
		end
		if (!ctrl && !seen_q && (is_out ? cur_full : is_in && !cur_full)) begin
			seen_d = 1'b1;
			flg_d.bctl = 1'b1;
			flg_d.out = flg_d.out || is_out;
			flg_d.txin = flg_d.txin || is_in;
		end
		if (rel_ev) begin
			flg_d.bctl = 1'b0;
			seen_d = 1'b0;
			ptr_d = '0;
			cbank_d = nb_c;
			full_d[cbank_q] = is_in;
			if (is_out) begin
				cnt_d[cbank_q] = '0;
			end
		end
		if (lnk_tok_i.valid) begin
			case (lnk_tok_i.kind)
				ubm_pkg::UBM_TOK_SETUP: begin
					rx_ok_d = ctrl;
					rx_setup_d = 1'b1;
					rx_retry_d = 1'b0;
					hptr_d = '0;
					if (ctrl) begin
						flg_d = ubm_pkg::FLAGS_RST;
						full_d[0] = 1'b0;
						cnt_d[0] = '0;
						ptr_d = '0;
						tx_busy_d = 1'b0;
						ctl_d = ubm_pkg::UBM_CT_IDLE;
					end
				end
				ubm_pkg::UBM_TOK_OUT: begin
					rx_setup_d = 1'b0;
					rx_retry_d = 1'b0;
					hptr_d = '0;
					rx_ok_d = is_out && !full_q[hb];
					if (ctrl) begin
						case (ctl_q)
							ubm_pkg::UBM_CT_IDLE, ubm_pkg::UBM_CT_WR: begin
								rx_ok_d = !full_q[0];
								ctl_d = full_q[0] ? ctl_q : ubm_pkg::UBM_CT_WR;
							end
							ubm_pkg::UBM_CT_RD: begin
								rx_ok_d = 1'b0;
								full_d[0] = 1'b0;
								cnt_d[0] = '0;
								ptr_d = '0;
								ctl_d = ubm_pkg::UBM_CT_RD_ST;
							end
							ubm_pkg::UBM_CT_RD_ST: begin
								rx_ok_d = 1'b1;
								rx_retry_d = 1'b1;
								ctl_d = ubm_pkg::UBM_CT_WAIT;
							end
							default: rx_ok_d = 1'b0;
						endcase
					end
				end
				ubm_pkg::UBM_TOK_IN: begin
					if ((ctrl || is_in) && full_q[hb]) begin
						tx_busy_d = 1'b1;
						hptr_d = '0;
						if (ctrl && ctl_q == ubm_pkg::UBM_CT_IDLE) begin
							ctl_d = ubm_pkg::UBM_CT_RD;
						end
					end else begin
						hs_d = '{valid: 1'b1, nak: 1'b1};
						flg_d.nak = flg_d.nak || (ctrl && ctl_q == ubm_pkg::UBM_CT_WR);
					end
				end
				default: rx_ok_d = 1'b0;
			endcase
		end
		if (lnk_rx_i.valid && rx_ok_q && hptr_q < PW'(BANK_BYTES)) begin
			mem_we = 1'b1;
			mem_wa = ma(hb, hptr_q);
			mem_wd = lnk_rx_i.data;
			hptr_d = hptr_q + 1'b1;
		end
		if (lnk_rx_i.eop) begin
			hs_d = '{valid: 1'b1, nak: !rx_ok_q};
			rx_ok_d = 1'b0;
			if (rx_ok_q) begin
				cnt_d[hb] = hptr_q;
				if (ctrl) begin
					flg_d.out = flg_d.out || !rx_setup_q;
					flg_d.setup = flg_d.setup || rx_setup_q;
					flg_d.txin = flg_d.txin || rx_retry_q;
					full_d[0] = !rx_retry_q;
				end else if (hptr_q == '0 && cfg_q.dfc && cfg_q.auto_sw) begin
					flg_d.zls = 1'b1;
				end else begin
					full_d[hb] = 1'b1;
					hbank_d = nb_h;
				end
			end
		end
		// A packet ends with a lone last strobe, so a zero-length packet is just that.
		if (tx_busy_q) begin
			if (hptr_q < cnt_q[hb]) begin
				tx_d = '{valid: 1'b1, last: 1'b0, data: mem_q[ma(hb, hptr_q)]};
				hptr_d = hptr_q + 1'b1;
			end else begin
				tx_d = '{valid: 1'b0, last: 1'b1, data: 8'h00};
				tx_busy_d = 1'b0;
				full_d[hb] = 1'b0;
				cnt_d[hb] = '0;
				hbank_d = nb_h;
				if (ctrl) begin
					flg_d.txin = 1'b1;
					ctl_d = (ctl_q == ubm_pkg::UBM_CT_WR) ? ubm_pkg::UBM_CT_WAIT : ctl_q;
				end
			end
		end
		irq_d = (flg_d.out && cfg_q.out_ie) || (flg_d.txin && cfg_q.in_ie) ||
			(flg_d.setup && cfg_q.setup_ie);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= ubm_pkg::CFG_RST;
			flg_q <= ubm_pkg::FLAGS_RST;
			ctl_q <= ubm_pkg::UBM_CT_WAIT;
			full_q <= '0;
			cnt_q <= '{default: '0};
			ptr_q <= '0;
			hptr_q <= '0;
			cbank_q <= 1'b0;
			hbank_q <= 1'b0;
			rx_ok_q <= 1'b0;
			rx_setup_q <= 1'b0;
			rx_retry_q <= 1'b0;
			tx_busy_q <= 1'b0;
			seen_q <= 1'b0;
			hs_q <= '0;
			tx_q <= '0;
			dfc_q <= 8'h00;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
			irq_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			flg_q <= flg_d;
			ctl_q <= ctl_d;
			full_q <= full_d;
			cnt_q <= cnt_d;
			ptr_q <= ptr_d;
			hptr_q <= hptr_d;
			cbank_q <= cbank_d;
			hbank_q <= hbank_d;
			rx_ok_q <= rx_ok_d;
			rx_setup_q <= rx_setup_d;
			rx_retry_q <= rx_retry_d;
			tx_busy_q <= tx_busy_d;
			seen_q <= seen_d;
			hs_q <= hs_d;
			tx_q <= tx_d;
			dfc_q <= dfc_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
			irq_q <= irq_d;
		end
	end

	// Bank storage has no reset; counts and full bits say what is valid.
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign lnk_hs_o = hs_q;
	assign lnk_tx_o = tx_q;
	assign dfc_rdata_o = dfc_q;
	assign ep_irq_o = irq_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_setup_ack: assert property (lnk_rx_i.eop && rx_setup_q && ctrl |=>
		hs_q.valid && !hs_q.nak && flg_q.setup && !flg_q.out) else $error("setup not acked");
	a_ctrl_bits_zero: assert property (
		req && !wb_we_i && wb_adr_i == ubm_pkg::ADDR_FLAGS && ctrl |=>
		!wb_dat_o[ubm_pkg::FLG_BCTL] && !wb_dat_o[ubm_pkg::FLG_RW_ALLOWED_FLAG]) else $error("ctrl bits set");
	a_nak_in_flag: assert property (lnk_tok_i.valid && lnk_tok_i.kind == ubm_pkg::UBM_TOK_IN &&
		ctrl && ctl_q == ubm_pkg::UBM_CT_WR && !full_q[0] |=> hs_q.nak && flg_q.nak)
		else $error("nak in flag missing");
	a_rd_status_nak: assert property (lnk_tok_i.valid && lnk_tok_i.kind == ubm_pkg::UBM_TOK_OUT &&
		ctrl && ctl_q == ubm_pkg::UBM_CT_RD ##1 lnk_rx_i.eop |=> hs_q.valid && hs_q.nak && !full_q[0])
		else $error("status not naked");
	a_discard_commit: assert property (ctrl && ctl_q == ubm_pkg::UBM_CT_RD_ST &&
		!lnk_tok_i.valid && wclr[ubm_pkg::FLG_TXIN] |=> !full_q[0]) else $error("commit not ignored");
	a_retry_flags: assert property (lnk_rx_i.eop && rx_retry_q && rx_ok_q |=>
		flg_q.out && flg_q.txin && !hs_q.nak) else $error("retry flags missing");
	a_setup_reset: assert property (lnk_tok_i.valid && lnk_tok_i.kind == ubm_pkg::UBM_TOK_SETUP &&
		ctrl |=> !flg_q.out && !flg_q.txin && !full_q[0] && cnt_q[0] == '0) else $error("setup no reset");
	a_zlp_count: assert property (lnk_rx_i.eop && rx_ok_q && hptr_q == '0 |=>
		cnt_q[$past(hb)] == '0) else $error("zlp count kept");
	a_out_full_flags: assert property (is_out && cur_full && !seen_q && !rel_ev &&
		!lnk_tok_i.valid |=> flg_q.out && flg_q.bctl) else $error("out flags missing");
	a_auto_no_clear: assert property (is_out && cfg_q.auto_sw && !rd_ev &&
		!wclr[ubm_pkg::FLG_FREE] |=> $stable(cbank_q)) else $error("auto bank switched");
	a_rw_allowed_flag_drops: assert property (is_out && last_rd && !cfg_q.auto_sw |=> !rw_allowed_flag)
		else $error("rw_allowed_flag stays high");
	a_zls_filter: assert property (lnk_rx_i.eop && rx_ok_q && is_out && hptr_q == '0 &&
		cfg_q.dfc && cfg_q.auto_sw |=> flg_q.zls && $stable(full_q)) else $error("zlp not filtered");

	c_setup: cover property (lnk_rx_i.eop && rx_setup_q ##1 flg_q.setup);
	c_status_retry: cover property (ctl_q == ubm_pkg::UBM_CT_RD_ST ##[1:40] ctl_q == ubm_pkg::UBM_CT_WAIT);
	c_auto_release: cover property (cfg_q.auto_sw && last_rd);
	c_in_commit: cover property (is_in && rel_ev ##[1:200] tx_q.last);

endmodule : ubm_bank_mgr

//--- ubm_host_model.sv
/*
 * Host-side model for the endpoint bank manager: sends SETUP, OUT and IN
 * tokens with packet bytes, records the handshake and counts the IN bytes seen.
 * Assumes the bank manager's link side on the same clock.
 */
`timescale 1ns/1ps
module ubm_host_model (
	// Clock
	input wire logic clk_i,
	// Link to the block
	output ubm_pkg::ubm_tok_t tok_o,
	output ubm_pkg::ubm_rx_t rx_o,
	input wire ubm_pkg::ubm_hs_t hs_i,
	input wire ubm_pkg::ubm_tx_t tx_i
);
	logic hs_seen;
	logic hs_nak;
	int tx_cnt;

	initial begin
		tok_o = '0;
		rx_o = '0;
	end

	// ****************************************************************
	// One transaction
	// ****************************************************************
	task automatic xfer(input ubm_pkg::ubm_tok_kind_t k, input int n);
		int i;
		hs_seen = 1'b0;
		hs_nak = 1'b0;
		tx_cnt = 0;
		@(posedge clk_i);
		tok_o <= '{1'b1, k};
		for (i = 0; i < n; i++) begin
			@(posedge clk_i);
			tok_o.valid <= 1'b0;
			rx_o <= '{1'b1, 1'b0, 8'h10 + 8'(i)};
		end
		@(posedge clk_i);
		tok_o.valid <= 1'b0;
		// Data is inverted once released so a stale byte is never mistaken for a fresh one.
		if (k != ubm_pkg::UBM_TOK_IN)
			rx_o <= '{1'b0, 1'b1, ~rx_o.data};
		for (i = 0; i < 80; i++) begin
			@(posedge clk_i);
			rx_o.eop <= 1'b0;
			if (tx_i.valid === 1'b1)
				tx_cnt++;
			if (hs_i.valid === 1'b1) begin
				hs_seen = 1'b1;
				hs_nak = hs_i.nak;
			end
			if (hs_seen || tx_i.last === 1'b1)
				break;
		end
	endtask : xfer
endmodule : ubm_host_model

//--- usb_endpoint_bank_manager_tb.sv
/*
 * Self-checking bench for the endpoint bank manager: a table of OUT
 * packets, then control, two-bank, flow controller and IN cases.
 * Assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ps
module usb_endpoint_bank_manager_tb;
	// ****************************************************************
	// Signals and helpers
	// ****************************************************************
	typedef struct {int n; int cnt;} ubm_row_t;
	localparam logic [31:0] ALL = 32'hffffffff;
	localparam logic [31:0] A_CFG = ubm_pkg::ADDR_CFG;
	localparam logic [31:0] A_FLG = ubm_pkg::ADDR_FLAGS;
	localparam logic [31:0] A_CNT = ubm_pkg::ADDR_COUNT;
	localparam logic [31:0] A_DAT = ubm_pkg::ADDR_DATA;
	localparam ubm_pkg::ubm_tok_kind_t TS = ubm_pkg::UBM_TOK_SETUP;
	localparam ubm_pkg::ubm_tok_kind_t TO = ubm_pkg::UBM_TOK_OUT;
	localparam ubm_pkg::ubm_tok_kind_t TI = ubm_pkg::UBM_TOK_IN;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic dfc_rd_i = 1'b0;
	logic [7:0] dfc_rdata_o;
	logic ep_irq_o;
	ubm_pkg::ubm_tok_t tok;
	ubm_pkg::ubm_rx_t rx;
	ubm_pkg::ubm_hs_t hs;
	ubm_pkg::ubm_tx_t tx;
	logic [31:0] rd;
	int errors = 0;
	int checks = 0;
	ubm_row_t rows [3] = '{'{0, 0}, '{3, 3}, '{70, 64}};

	ubm_bank_mgr i_ubm_bank_mgr (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.lnk_tok_i(tok), .lnk_rx_i(rx), .lnk_hs_o(hs), .lnk_tx_o(tx),
		.dfc_rd_i(dfc_rd_i), .dfc_wr_i(1'b0), .dfc_wdata_i(8'h0),
		.dfc_rdata_o(dfc_rdata_o), .ep_irq_o(ep_irq_o)
	);
	ubm_host_model i_ubm_host_model (
		.clk_i(clk_i), .tok_o(tok), .rx_o(rx), .hs_i(hs), .tx_i(tx)
	);

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		n = 0;
		// Only the ack ends a wait; the slave sets the pace and the watchdog catches a hang.
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		chk({31'h0, wb_ack_o}, 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic rdm(input logic [31:0] adr, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, adr, 32'h0);
		chk(rd & m, e);
	endtask : rdm

	task automatic pk(input ubm_pkg::ubm_tok_kind_t k, input int n, input logic [31:0] e);
		i_ubm_host_model.xfer(k, n);
		chk({30'h0, i_ubm_host_model.hs_seen, i_ubm_host_model.hs_nak}, e);
	endtask : pk

	task automatic start(input logic [31:0] c);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, A_CFG, c);
	endtask : start

	task automatic summarize();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial begin
		repeat (40000) @(posedge clk_i);
		errors++;
		summarize();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdm(A_CFG, ALL, 32'h0);
		rdm(A_FLG, ALL, 32'h0);
		rdm(32'h10, ALL, 32'h0);
		$display("test reset done");
		foreach (rows[r]) begin
			start(32'h21);
			pk(TO, rows[r].n, 32'h2);
			rdm(A_FLG, ALL, rows[r].cnt > 0 ? 32'h184 : 32'h84);
			chk({31'h0, ep_irq_o}, 32'h1);
			rdm(A_CNT, ALL, 32'(rows[r].cnt));
			for (int i = 0; i < rows[r].cnt; i++)
				rdm(A_DAT, ALL, 32'h10 + 32'(i));
			rdm(A_FLG, ALL, 32'h84);
			wb(1'b1, A_FLG, 32'h4);
			wb(1'b1, A_FLG, 32'h80);
			rdm(A_FLG, ALL, 32'h0);
			chk({31'h0, ep_irq_o}, 32'h0);
			$display("test out row %0d done", r);
		end
		start(32'h80);
		pk(TS, 8, 32'h2);
		rdm(A_FLG, ALL, 32'h8);
		chk({31'h0, ep_irq_o}, 32'h1);
		rdm(A_CNT, ALL, 32'h8);
		wb(1'b1, A_FLG, 32'h8);
		rdm(A_CNT, ALL, 32'h0);
		rdm(A_FLG, ALL, 32'h1);
		wb(1'b1, A_DAT, 32'h5a);
		wb(1'b1, A_FLG, 32'h1);
		pk(TI, 0, 32'h0);
		chk(32'(i_ubm_host_model.tx_cnt), 32'h1);
		wb(1'b1, A_DAT, 32'h33);
		pk(TO, 0, 32'h3);
		rdm(A_CNT, ALL, 32'h0);
		wb(1'b1, A_DAT, 32'h44);
		wb(1'b1, A_FLG, 32'h1);
		pk(TI, 0, 32'h3);
		pk(TO, 0, 32'h2);
		rdm(A_FLG, ALL, 32'h5);
		pk(TO, 0, 32'h3);
		pk(TS, 8, 32'h2);
		rdm(A_FLG, ALL, 32'h8);
		$display("test control read done");
		start(32'h0);
		pk(TS, 8, 32'h2);
		wb(1'b1, A_FLG, 32'h8);
		pk(TO, 2, 32'h2);
		wb(1'b1, A_FLG, 32'h4);
		pk(TI, 0, 32'h3);
		rdm(A_FLG, 32'h40, 32'h40);
		$display("test control write done");
		start(32'h11);
		pk(TO, 2, 32'h2);
		pk(TO, 3, 32'h2);
		wb(1'b1, A_FLG, 32'h4);
		wb(1'b1, A_FLG, 32'h80);
		rdm(A_FLG, ALL, 32'h184);
		rdm(A_CNT, ALL, 32'h3);
		$display("test two banks done");
		start(32'h5);
		pk(TO, 2, 32'h2);
		wb(1'b1, A_FLG, 32'h80);
		rdm(A_CNT, ALL, 32'h2);
		rdm(A_DAT, ALL, 32'h10);
		rdm(A_DAT, ALL, 32'h11);
		rdm(A_FLG, 32'h180, 32'h0);
		start(32'hd);
		pk(TO, 0, 32'h2);
		rdm(A_FLG, 32'h204, 32'h200);
		start(32'h9);
		pk(TO, 1, 32'h2);
		wb(1'b1, A_FLG, 32'h4);
		@(posedge clk_i);
		dfc_rd_i <= 1'b1;
		@(posedge clk_i);
		dfc_rd_i <= 1'b0;
		@(posedge clk_i);
		chk({24'h0, dfc_rdata_o}, 32'h10);
		rdm(A_FLG, ALL, 32'h80);
		wb(1'b1, A_FLG, 32'h80);
		rdm(A_FLG, ALL, 32'h0);
		$display("test auto and flow controller done");
		start(32'h42);
		rdm(A_FLG, ALL, 32'h181);
		chk({31'h0, ep_irq_o}, 32'h1);
		for (int i = 0; i < 3; i++)
			wb(1'b1, A_DAT, 32'h20 + 32'(i));
		wb(1'b1, A_FLG, 32'h1);
		wb(1'b1, A_FLG, 32'h80);
		pk(TI, 0, 32'h0);
		chk(32'(i_ubm_host_model.tx_cnt), 32'h3);
		rdm(A_FLG, 32'h81, 32'h81);
		start(32'h46);
		wb(1'b1, A_FLG, 32'h1);
		for (int i = 0; i < 64; i++)
			wb(1'b1, A_DAT, 32'(i));
		rdm(A_FLG, 32'h80, 32'h0);
		chk({31'h0, ep_irq_o}, 32'h0);
		pk(TI, 0, 32'h0);
		chk(32'(i_ubm_host_model.tx_cnt), 32'h40);
		@(posedge clk_i);
		@(posedge clk_i);
		chk({31'h0, ep_irq_o}, 32'h1);
		$display("test in endpoint done");
		start(32'h80);
		chk({31'h0, ep_irq_o}, 32'h0);
		rdm(A_FLG, ALL, 32'h0);
		rdm(A_CNT, ALL, 32'h0);
		$display("test mid-run reset done");
		summarize();
	end
endmodule : usb_endpoint_bank_manager_tb
